// ---- anps_link_partner.sv ----
// behavioural link partner driving the negotiation side of the block
module anps_link_partner (
    // clock
    input  wire logic        clk_i,
    // negotiation side
    output logic             lcw_valid_o,
    output logic      [15:0] lcw_o,
    output logic             base_page_o,
    output logic             par_fault_o,
    output logic             np_able_o,
    output logic             an_able_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // idle levels at time zero
    initial
    begin
        lcw_valid_o = 1'b0;
        base_page_o = 1'b0;
        par_fault_o = 1'b0;
        np_able_o   = 1'b0;
        an_able_o   = 1'b0;
    end

    // one word per call; the released bus shows the inverse, never stale
    task automatic send_word(input logic [15:0] w);
        @(posedge clk_i);
        lcw_valid_o <= 1'b1;
        lcw_o       <= w;
        @(posedge clk_i);
        lcw_valid_o <= 1'b0;
        lcw_o       <= ~w;
    endtask

    // back-to-back words: one differing word, then three equal ones
    task automatic send_burst(input logic [15:0] w);
        @(posedge clk_i);
        lcw_valid_o <= 1'b1;
        lcw_o       <= ~w;
        repeat (3)
        begin
            @(posedge clk_i);
            lcw_o <= w;
        end
        @(posedge clk_i);
        lcw_valid_o <= 1'b0;
        lcw_o       <= ~w;
    endtask

    // ability levels as the partner advertises them
    task automatic set_levels(input logic bp, input logic np, input logic an);
        @(posedge clk_i);
        base_page_o <= bp;
        np_able_o   <= np;
        an_able_o   <= an;
    endtask

    // single-cycle fault from parallel detection
    task automatic fault_pulse();
        @(posedge clk_i);
        par_fault_o <= 1'b1;
        @(posedge clk_i);
        par_fault_o <= 1'b0;
    endtask
endmodule

// ---- anps_pkg.sv ----
// constants for the auto-negotiation page and status register group
package anps_pkg;

    // ========================================================
    // register indexes and byte addresses
    localparam logic [5:0] ANPS_IDX_PARTNER   = 6'h05;
    localparam logic [5:0] ANPS_IDX_EXPANSION = 6'h06;
    localparam logic [5:0] ANPS_IDX_NEXT_PAGE = 6'h07;
    localparam logic [5:0] ANPS_IDX_IRQ_STS   = 6'h10;
    localparam logic [5:0] ANPS_IDX_IRQ_MASK  = 6'h11;
    localparam logic [7:0] ANPS_ADDR_PARTNER   = {ANPS_IDX_PARTNER, 2'b00};
    localparam logic [7:0] ANPS_ADDR_EXPANSION = {ANPS_IDX_EXPANSION, 2'b00};
    localparam logic [7:0] ANPS_ADDR_NEXT_PAGE = {ANPS_IDX_NEXT_PAGE, 2'b00};
    localparam logic [7:0] ANPS_ADDR_IRQ_STS   = {ANPS_IDX_IRQ_STS, 2'b00};
    localparam logic [7:0] ANPS_ADDR_IRQ_MASK  = {ANPS_IDX_IRQ_MASK, 2'b00};

    // ========================================================
    // expansion register bit positions
    localparam int ANPS_EXP_BASE_PAGE = 5;
    localparam int ANPS_EXP_PAR_FAULT = 4;
    localparam int ANPS_EXP_LP_NP     = 3;
    localparam int ANPS_EXP_LOCAL_NP  = 2;
    localparam int ANPS_EXP_PAGE_RX   = 1;
    localparam int ANPS_EXP_LP_AN     = 0;

    // ========================================================
    // outgoing next page word layout and reset value
    localparam int ANPS_NP_MORE_PAGES = 15;
    localparam int ANPS_NP_RSVD       = 14;
    localparam int ANPS_NP_MSG_KIND   = 13;
    localparam int ANPS_NP_COMPLY     = 12;
    localparam int ANPS_NP_TOGGLE     = 11;
    localparam logic [15:0] ANPS_NP_RST = 16'h2001;

    // ========================================================
    // partner word layout, reset values, counts
    localparam int ANPS_PARTNER_BITS = 7;
    localparam logic [6:0] ANPS_PARTNER_RST = 7'h00;
    localparam logic [1:0] ANPS_MATCH_COUNT = 2'h3;
    localparam int ANPS_IRQ_PAGE_RX   = 0;
    localparam int ANPS_IRQ_PAR_FAULT = 1;
    localparam logic [1:0] ANPS_IRQ_RST = 2'h0;

endpackage

// ---- anps_regs.sv ----
// auto-negotiation partner, expansion and next page registers on apb
//
// The implementer's own choice: register access over APB.
module anps_regs (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // negotiation state machine side
    input  wire logic        lcw_valid_i,
    input  wire logic [15:0] lcw_i,
    input  wire logic        base_page_i,
    input  wire logic        par_fault_i,
    input  wire logic        lp_np_able_i,
    input  wire logic        lp_an_able_i,
    output logic      [15:0] np_word_o,
    // interrupt
    output logic             irq_o
);

    // ========================================================
    // state
    logic [6:0]  partner_q;
    logic [15:0] last_lcw_q;
    logic [1:0]  match_cnt_q;
    logic        pdf_q;
    logic        page_rx_q;
    logic [15:0] np_q;
    logic [1:0]  irq_sts_q;
    logic [1:0]  irq_mask_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;
    logic        irq_q;

    // ========================================================
    // apb decode
    wire         access    = psel_i & penable_i;
    wire         take      = access & ~pready_q;   // first access cycle
    wire         done      = access & pready_q;    // completion edge
    wire         hit_part  = paddr_i == anps_pkg::ANPS_ADDR_PARTNER;
    wire         hit_exp   = paddr_i == anps_pkg::ANPS_ADDR_EXPANSION;
    wire         hit_np    = paddr_i == anps_pkg::ANPS_ADDR_NEXT_PAGE;
    wire         hit_sts   = paddr_i == anps_pkg::ANPS_ADDR_IRQ_STS;
    wire         hit_mask  = paddr_i == anps_pkg::ANPS_ADDR_IRQ_MASK;
    wire         mapped    = hit_part | hit_exp | hit_np | hit_sts | hit_mask;
    wire         wr_done   = done & pwrite_i & mapped;
    wire         exp_rd    = done & ~pwrite_i & hit_exp;

    // ========================================================
    // link code word matching
    // a repeat counts while valid words arrive unchanged; idle cycles between them do not restart it
    wire         same_word = lcw_i == last_lcw_q;
    wire         page_hit  = lcw_valid_i & same_word &
                             (match_cnt_q == anps_pkg::ANPS_MATCH_COUNT - 2'h1);
    wire [1:0]   cnt_inc   = (match_cnt_q == anps_pkg::ANPS_MATCH_COUNT) ?
                             match_cnt_q : match_cnt_q + 2'h1;
    wire [1:0]   cnt_d     = same_word ? cnt_inc : 2'h1;

    // ========================================================
    // read views
    wire [15:0]  exp_view  = {10'h000,
                              base_page_i,
                              pdf_q,
                              lp_np_able_i,
                              1'b1,
                              page_rx_q,
                              lp_an_able_i};
    wire [15:0]  part_view = {9'h000, partner_q};
    wire [31:0]  rd_data   = hit_part ? {16'h0000, part_view} :
                             hit_exp  ? {16'h0000, exp_view} :
                             hit_np   ? {16'h0000, np_q} :
                             hit_sts  ? {30'h0, irq_sts_q} :
                             hit_mask ? {30'h0, irq_mask_q} : 32'h0;

    // ========================================================
    // next page word write value, bit 14 forced low
    wire [15:0]  np_d      = {pwdata_i[15], 1'b0, pwdata_i[13:0]};
    wire [1:0]   irq_ev    = {par_fault_i, page_hit};
    wire [1:0]   sts_clr   = (done & pwrite_i & hit_sts) ?
                             pwdata_i[1:0] : 2'h0;

    // ========================================================
    // apb answer: one wait state, data registered for clean outputs
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q  <= take;
            pslverr_q <= take & ~mapped;
            if (take & ~pwrite_i)
                prdata_q <= rd_data;
        end
    end

    // ========================================================
    // code word counter
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            last_lcw_q  <= 16'h0000;
            match_cnt_q <= 2'h0;
        end
        else if (lcw_valid_i)
        begin
            last_lcw_q  <= lcw_i;
            match_cnt_q <= cnt_d;
        end
    end

    // ========================================================
    // partner base page capture on an accepted base page
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            partner_q <= anps_pkg::ANPS_PARTNER_RST;
        else if (page_hit & base_page_i)
            partner_q <= lcw_i[6:0];
    end

    // ========================================================
    // latching-high flags; a new event wins over the read clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            pdf_q     <= 1'b0;
            page_rx_q <= 1'b0;
        end
        else
        begin
            pdf_q     <= par_fault_i | (pdf_q & ~exp_rd);
            page_rx_q <= page_hit | (page_rx_q & ~exp_rd);
        end
    end

    // ========================================================
    // outgoing next page word
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
            np_q <= anps_pkg::ANPS_NP_RST;
        else if (wr_done & hit_np)
            np_q <= np_d;
    end

    // ========================================================
    // interrupt status, mask and level output
    always_ff @(posedge clk_i)
    begin
        if (!rst_n_i)
        begin
            irq_sts_q  <= anps_pkg::ANPS_IRQ_RST;
            irq_mask_q <= anps_pkg::ANPS_IRQ_RST;
            irq_q      <= 1'b0;
        end
        else
        begin
            irq_sts_q <= irq_ev | (irq_sts_q & ~sts_clr);
            if (wr_done & hit_mask)
                irq_mask_q <= pwdata_i[1:0];
            irq_q <= |(irq_sts_q & irq_mask_q);
        end
    end

    // ========================================================
    // outputs
    assign prdata_o  = prdata_q;
    assign pready_o  = pready_q;
    assign pslverr_o = pslverr_q;
    assign np_word_o = np_q;
    assign irq_o     = irq_q;

    // ========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    a_partner_ability_load:
        assert property (page_hit && base_page_i |=>
            partner_q[6:5] == $past(lcw_i[6:5]))
        else $error("partner ability bits not captured");

    a_partner_sel_load:
        assert property (page_hit && base_page_i ##1 !(page_hit && base_page_i)
            |=> partner_q[4:0] == $past(lcw_i[4:0], 2))
        else $error("partner selector not held");

    a_base_page_view:
        assert property (take && !pwrite_i && hit_exp |=>
            prdata_o[5] == $past(base_page_i))
        else $error("base page bit not mirrored");

    a_fault_latch:
        assert property (par_fault_i |=> pdf_q [*1] ##0 exp_view[4])
        else $error("fault flag not latched");

    a_fault_hold:
        assert property (pdf_q && !exp_rd |=> pdf_q)
        else $error("fault flag dropped before read");

    a_lp_np_view:
        assert property (take && !pwrite_i && hit_exp |=>
            prdata_o[3] == $past(lp_np_able_i) && prdata_o[0] ==
            $past(lp_an_able_i))
        else $error("partner ability flags wrong");

    a_local_np_view:
        assert property (take && !pwrite_i && hit_exp |=>
            prdata_o[2] && prdata_o[31:6] == 26'h0)
        else $error("local next page or reserved bits wrong");

    a_page_rx_set:
        assert property (lcw_valid_i && !same_word ##1 lcw_valid_i &&
            same_word ##1 lcw_valid_i && same_word |=> page_rx_q)
        else $error("page received not set after three words");

    a_np_rsvd_zero:
        assert property (np_word_o[14] == 1'b0)
        else $error("next page bit 14 not zero");

    a_np_write:
        assert property (done && pwrite_i && hit_np |=>
            np_word_o[15] == $past(pwdata_i[15]) && np_word_o[13:0] ==
            $past(pwdata_i[13:0]))
        else $error("next page write lost");

    a_read_clears:
        assert property (exp_rd && !par_fault_i && !page_hit |=>
            !pdf_q && !page_rx_q)
        else $error("latched flags not cleared by read");

    a_apb_wait:
        assert property (take |=> pready_o ##1 !pready_o)
        else $error("apb answer timing wrong");

    a_irq_level:
        assert property ((irq_sts_q & irq_mask_q) != 2'h0 |=> irq_o)
        else $error("interrupt not raised");

    // ========================================================
    // holds, refusals and status events; reset must be held two edges for $stable
    a_partner_hold:
        assert property (!(page_hit && base_page_i) |=> $stable(partner_q))
        else $error("partner word changed without a base page");

    a_page_rx_hold:
        assert property (page_rx_q && !exp_rd |=> page_rx_q)
        else $error("page received dropped before read");

    a_np_hold:
        assert property (!(wr_done && hit_np) |=> $stable(np_word_o))
        else $error("next page word changed without a write");

    a_err_unmapped:
        assert property (take && !mapped |=> pready_o && pslverr_o)
        else $error("unmapped access not refused");

    a_err_mapped:
        assert property (take && mapped |=> pready_o && !pslverr_o)
        else $error("mapped access flagged as error");

    a_irq_quiet:
        assert property ((irq_sts_q & irq_mask_q) == 2'h0 |=> !irq_o)
        else $error("interrupt raised while nothing pending");

    a_sts_page_ev:
        assert property (page_hit |=> irq_sts_q[anps_pkg::ANPS_IRQ_PAGE_RX])
        else $error("page received event not in status");

    a_sts_fault_ev:
        assert property (par_fault_i |=>
            irq_sts_q[anps_pkg::ANPS_IRQ_PAR_FAULT])
        else $error("fault event not in status");

endmodule

// ---- tb_top.sv ----
// self-checking bench for the negotiation page and status registers
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // signals and counters
    logic        clk_i, rst_n_i, psel_i, penable_i, pwrite_i, pready_o;
    logic        pslverr_o, irq_o, lcw_valid_i, base_page_i, par_fault_i;
    logic        lp_np_able_i, lp_an_able_i, err;
    logic [7:0]  paddr_i;
    logic [15:0] lcw_i, np_word_o;
    logic [31:0] pwdata_i, prdata_o, rd;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;

    anps_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .lcw_valid_i(lcw_valid_i), .lcw_i(lcw_i),
        .base_page_i(base_page_i), .par_fault_i(par_fault_i),
        .lp_np_able_i(lp_np_able_i), .lp_an_able_i(lp_an_able_i),
        .np_word_o(np_word_o), .irq_o(irq_o));
    anps_link_partner u_lp (.clk_i(clk_i), .lcw_valid_o(lcw_valid_i),
        .lcw_o(lcw_i), .base_page_o(base_page_i), .par_fault_o(par_fault_i),
        .np_able_o(lp_np_able_i), .an_able_o(lp_an_able_i));

    // ========================================================
    // clock and hang guard; tests need about 150 cycles
    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    // ========================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // idle edge first so release and next setup never share a step
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        @(posedge clk_i);
        psel_i   <= 1'b1;
        pwrite_i <= wr;
        paddr_i  <= a;
        pwdata_i <= wd;
        @(posedge clk_i);
        penable_i <= 1'b1;
        do
        begin
            @(posedge clk_i);
        end
        while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // ========================================================
    // scenarios
    task automatic t_reset();
        apb(1'b0, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_0004);
        apb(1'b0, anps_pkg::ANPS_ADDR_NEXT_PAGE, 32'h0);
        chk(rd, 32'h0000_2001);
        chk({16'h0, np_word_o}, 32'h0000_2001);
        $display("test reset values done");
    endtask

    // a differing word restarts the match count
    task automatic t_page_rx();
        u_lp.set_levels(1'b1, 1'b1, 1'b1);
        u_lp.send_word(16'h0061);
        u_lp.send_word(16'h0061);
        u_lp.send_word(16'h0041);
        u_lp.send_word(16'h0061);
        u_lp.send_word(16'h0061);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_002D);
        apb(1'b0, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk(rd, 32'h0);
        u_lp.send_word(16'h0061);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_002F);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_002D);
        apb(1'b0, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk(rd, 32'h0000_0061);
        $display("test page received done");
    endtask

    // masked page flag must not raise the line, fault must
    task automatic t_fault_irq();
        apb(1'b1, anps_pkg::ANPS_ADDR_IRQ_MASK, 32'h2);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        u_lp.fault_pulse();
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h1);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_003D);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_002D);
        apb(1'b1, anps_pkg::ANPS_ADDR_IRQ_STS, 32'h2);
        repeat (3) @(posedge clk_i);
        chk({31'h0, irq_o}, 32'h0);
        apb(1'b0, anps_pkg::ANPS_ADDR_IRQ_STS, 32'h0);
        chk(rd, 32'h1);
        $display("test fault and interrupt done");
    endtask

    task automatic t_next_page();
        apb(1'b1, anps_pkg::ANPS_ADDR_NEXT_PAGE, 32'hFFFF_BFFF);
        apb(1'b0, anps_pkg::ANPS_ADDR_NEXT_PAGE, 32'h0);
        chk(rd, 32'h0000_BFFF);
        chk({16'h0, np_word_o}, 32'h0000_BFFF);
        apb(1'b1, anps_pkg::ANPS_ADDR_NEXT_PAGE, 32'h0);
        @(posedge clk_i);
        chk({16'h0, np_word_o}, 32'h0);
        $display("test next page done");
    endtask

    task automatic t_refused();
        apb(1'b1, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b1, 8'h00, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 8'h3C, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk(rd, 32'h0000_0061);
        $display("test refused access done");
    endtask

    // back-to-back words with base page low, then a mid-run reset
    task automatic t_burst_reset();
        u_lp.set_levels(1'b0, 1'b1, 1'b1);
        u_lp.send_burst(16'h0042);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_000F);
        apb(1'b0, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk(rd, 32'h0000_0061);
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        apb(1'b0, anps_pkg::ANPS_ADDR_PARTNER, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, anps_pkg::ANPS_ADDR_EXPANSION, 32'h0);
        chk(rd, 32'h0000_000D);
        apb(1'b0, anps_pkg::ANPS_ADDR_NEXT_PAGE, 32'h0);
        chk(rd, 32'h0000_2001);
        $display("test burst and mid-run reset done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ========================================================
    // main sequence
    initial
    begin
        rst_n_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_page_rx();
        t_fault_irq();
        t_next_page();
        t_refused();
        t_burst_reset();
        tally_and_finish();
    end
endmodule
